// File: mbcs_map.svh
/*
  Register map, field positions, limits and reset values of the serial master command scheduler.
  Assumes inclusion by the design file only.
*/
`ifndef MBCS_MAP_SVH
`define MBCS_MAP_SVH

// ----------------------------------------------------------------------------
// register offsets (byte addresses) and table/database page numbers
// ----------------------------------------------------------------------------
`define MBCS_REG_CTRL     20'h00000
`define MBCS_REG_STATUS   20'h00004
`define MBCS_REG_TRIG     20'h00008
`define MBCS_TBL_PAGE     12'h001
`define MBCS_DB_PAGE      4'h1

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define MBCS_CTRL_RUN     0
`define MBCS_ST_ERR       8
`define MBCS_ST_TMO       9
`define MBCS_ST_BUSY      4
`define MBCS_W0_MODE      0
`define MBCS_W0_SWAP      4
`define MBCS_W0_FC        8
`define MBCS_W0_NODE      16
`define MBCS_W2_POLL      16

// ----------------------------------------------------------------------------
// sizes, limits and reset values
// ----------------------------------------------------------------------------
`define MBCS_NUM_ENT      16
`define MBCS_DB_WORDS     14'd10000
`define MBCS_BIT_LIMIT    19'd160000
`define MBCS_WORD_LIMIT   19'd10000
`define MBCS_REG_CNT_MAX  10'd125
`define MBCS_BIT_CNT_MAX  10'd800
`define MBCS_NODE_BCAST   8'h00
`define MBCS_FIFO_DEPTH   16
`define MBCS_CTRL_RESET   1'b0

`endif

// File: mbcs_pkg.sv
/*
  Types of the serial master command scheduler: run modes, function codes, swap codes, scheduler states.
  Assumes nothing of its surroundings.
*/
package mbcs_pkg;

  typedef enum logic [1:0] {
    MODE_DISABLED = 2'b00,
    MODE_CONT     = 2'b01,
    MODE_EVENT    = 2'b10,
    MODE_COND     = 2'b11
  } mbcs_mode_e;

  typedef enum logic [1:0] {
    SWAP_NONE = 2'b00,
    SWAP_WORD = 2'b01,
    SWAP_BOTH = 2'b10,
    SWAP_BYTE = 2'b11
  } mbcs_swap_e;

  typedef enum logic [7:0] {
    FC_RD_COILS = 8'h01,
    FC_RD_INBIT = 8'h02,
    FC_RD_HOLD  = 8'h03,
    FC_RD_INREG = 8'h04,
    FC_WR_COIL  = 8'h05,
    FC_WR_REG   = 8'h06,
    FC_WR_COILS = 8'h0F,
    FC_WR_REGS  = 8'h10
  } mbcs_fc_e;

  typedef enum logic [2:0] {
    S_IDLE  = 3'b000,
    S_CHECK = 3'b001,
    S_HDR0  = 3'b010,
    S_HDR1  = 3'b011,
    S_DATA  = 3'b100,
    S_WAIT  = 3'b101
  } mbcs_state_e;

endpackage

// File: mbcs_top.sv
/*
  Serial master command scheduler: command table, word/bit database, scan and trigger logic,
  request FIFO towards the serial master driver.
  Assumes an APB master, a one-cycle seconds tick, and a driver that reports done or timeout per request.
*/
`include "mbcs_map.svh"
`timescale 1ns/1ps
`default_nettype none

module mbcs_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16
) (
  input  wire logic             pclk,      // clock
  input  wire logic             presetn,   // async reset, low
  input  wire logic             ce,        // clock enable
  input  wire logic             in_valid,  // write request
  output logic                  in_ready,  // not full
  input  wire logic [WIDTH-1:0] in_data,   // write data
  output logic                  out_valid, // not empty
  input  wire logic             out_ready, // read request
  output logic      [WIDTH-1:0] out_data   // head word
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [0:DEPTH-1];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      fill;
  wire              do_wr = in_valid && in_ready && ce;
  wire              do_rd = out_valid && out_ready && ce;

  assign in_ready  = (fill != (AW+1)'(DEPTH));
  assign out_valid = (fill != '0);
  assign out_data  = mem[rd_ptr];

  always_ff @(posedge pclk)
  begin
    if (do_wr)
    begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      fill   <= '0;
    end
    else
    begin
      if (do_wr) wr_ptr <= wr_ptr + 1'b1;
      if (do_rd) rd_ptr <= rd_ptr + 1'b1;
      fill <= fill + {{AW{1'b0}}, do_wr} - {{AW{1'b0}}, do_rd};
    end
  end
endmodule

module mbcs_top
  import mbcs_pkg::*;
(
  input  wire logic        pclk,         // clock, 100 MHz
  input  wire logic        presetn,      // async reset, low
  input  wire logic        ce,           // clock enable, freezes all state
  input  wire logic        psel,         // apb select
  input  wire logic        penable,      // apb access phase
  input  wire logic        pwrite,       // apb direction
  input  wire logic [19:0] paddr,        // apb byte address
  input  wire logic [31:0] pwdata,       // apb write data
  output logic      [31:0] prdata,       // apb read data
  output logic             pready,       // apb ready
  output logic             pslverr,      // apb error, unmapped
  input  wire logic        sec_tick,     // one-cycle seconds tick
  output logic             req_valid,    // request word available
  input  wire logic        req_ready,    // driver takes word
  output logic      [31:0] req_data,     // request word
  input  wire logic        resp_valid,   // read data word from driver
  output logic             resp_ready,   // scheduler takes read word
  input  wire logic [31:0] resp_data,    // read data, two words
  input  wire logic        resp_done,    // request finished
  input  wire logic        resp_timeout  // request timed out
);
  localparam int N = `MBCS_NUM_ENT;

  // --------------------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------------------
  function automatic logic [31:0] f_swap(input logic [31:0] x, input logic [1:0] code);
    case (code)
      SWAP_WORD: f_swap = {x[15:0], x[31:16]};
      SWAP_BOTH: f_swap = {x[7:0], x[15:8], x[23:16], x[31:24]};
      SWAP_BYTE: f_swap = {x[23:16], x[31:24], x[7:0], x[15:8]};
      default:   f_swap = x;
    endcase
  endfunction

  function automatic logic f_isbit(input logic [7:0] fc);
    f_isbit = (fc == FC_RD_COILS) || (fc == FC_RD_INBIT) || (fc == FC_WR_COIL) || (fc == FC_WR_COILS);
  endfunction

  function automatic logic f_iswr(input logic [7:0] fc);
    f_iswr = (fc == FC_WR_COIL) || (fc == FC_WR_REG) || (fc == FC_WR_COILS) || (fc == FC_WR_REGS);
  endfunction

  function automatic logic [9:0] f_cnt(input logic [7:0] fc, input logic [9:0] cnt);
    f_cnt = ((fc == FC_WR_COIL) || (fc == FC_WR_REG)) ? 10'h001 : cnt;
  endfunction

  function automatic logic [13:0] f_ws(input logic [7:0] fc, input logic [17:0] ia);
    f_ws = f_isbit(fc) ? ia[17:4] : ia[13:0];
  endfunction

  function automatic logic [7:0] f_nw(input logic [7:0] fc, input logic [17:0] ia, input logic [9:0] cnt);
    logic [10:0] s;
    s = {7'h00, ia[3:0]} + {1'b0, f_cnt(fc, cnt)} + 11'h00F;
    f_nw = f_isbit(fc) ? {1'b0, s[10:4]} : ((fc == FC_WR_REG) ? 8'h01 : cnt[7:0]);
  endfunction

  function automatic logic [15:0] f_mask(input logic isbit, input logic [13:0] wa,
                                         input logic [17:0] bs, input logic [9:0] cnt);
    logic [18:0] g;
    logic [18:0] lim;
    f_mask = 16'hFFFF;
    lim    = {1'b0, bs} + {9'h000, cnt};
    for (int b = 0; b < 16; b++)
    begin
      g = {1'b0, wa, 4'h0} + 19'(b);
      if (isbit && (g < {1'b0, bs} || g >= lim)) f_mask[b] = 1'b0;
    end
  endfunction

  // --------------------------------------------------------------------------
  // apb decode
  // --------------------------------------------------------------------------
  logic        run;
  logic        err_st;
  logic        tmo_st;
  mbcs_state_e state;
  mbcs_state_e next_state;
  logic [3:0]  cur_idx;
  logic [3:0]  scan_idx;
  logic        from_scan;
  logic [7:0]  ptr;

  wire        apb_setup = psel && !penable;
  wire        apb_wr    = psel && penable && pwrite && ce;
  wire        tbl_hit   = (paddr[19:8] == `MBCS_TBL_PAGE);
  wire [3:0]  tbl_idx   = paddr[7:4];
  wire [1:0]  tbl_word  = paddr[3:2];
  wire [13:0] db_idx    = paddr[15:2];
  wire        db_hit    = (paddr[19:16] == `MBCS_DB_PAGE) && (db_idx < `MBCS_DB_WORDS);
  wire        ctrl_hit  = (paddr == `MBCS_REG_CTRL);
  wire        stat_hit  = (paddr == `MBCS_REG_STATUS);
  wire        trig_hit  = (paddr == `MBCS_REG_TRIG);
  wire        mapped    = tbl_hit || db_hit || ctrl_hit || stat_hit || trig_hit;
  wire        apb_db_wr = apb_wr && db_hit;
  wire        trig_wr   = apb_wr && trig_hit;
  wire        stat_wr   = apb_wr && stat_hit;

  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped;

  // --------------------------------------------------------------------------
  // command table and per-entry scheduling state
  // --------------------------------------------------------------------------
  logic [1:0]  e_mode [0:N-1];
  logic [1:0]  e_swap [0:N-1];
  logic [7:0]  e_fc   [0:N-1];
  logic [7:0]  e_node [0:N-1];
  logic [17:0] e_ia   [0:N-1];
  logic [9:0]  e_cnt  [0:N-1];
  logic [15:0] e_poll [0:N-1];
  logic [15:0] e_ra   [0:N-1];
  logic [N-1:0] due;
  logic [N-1:0] trig;
  wire          issue = (state == S_CHECK) && ce;

  genvar gi;
  generate
    for (gi = 0; gi < N; gi++)
    begin : g_ent
      logic        dirty;
      logic [16:0] tmr;
      wire         wr_ent = apb_wr && tbl_hit && (tbl_idx == 4'(gi));
      wire         mine   = issue && (cur_idx == 4'(gi));
      wire [13:0]  ws     = f_ws(e_fc[gi], e_ia[gi]);
      wire [14:0]  we     = {1'b0, ws} + {7'h00, f_nw(e_fc[gi], e_ia[gi], e_cnt[gi])};
      wire         touch  = apb_db_wr && (db_idx >= ws) && ({1'b0, db_idx} < we);

      assign due[gi] = ((e_mode[gi] == MODE_CONT) && (tmr == '0))
                     || ((e_mode[gi] == MODE_EVENT || e_mode[gi] == MODE_COND) && dirty);

      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          e_mode[gi] <= MODE_DISABLED;
          e_swap[gi] <= SWAP_NONE;
          e_fc[gi]   <= 8'h00;
          e_node[gi] <= 8'h00;
          e_ia[gi]   <= 18'h00000;
          e_cnt[gi]  <= 10'h000;
          e_poll[gi] <= 16'h0000;
          e_ra[gi]   <= 16'h0000;
          dirty      <= 1'b0;
          tmr        <= 17'h00000;
          trig[gi]   <= 1'b0;
        end
        else if (ce)
        begin
          if (wr_ent && tbl_word == 2'h0)
          begin
            e_mode[gi] <= pwdata[`MBCS_W0_MODE +: 2];
            e_swap[gi] <= pwdata[`MBCS_W0_SWAP +: 2];
            e_fc[gi]   <= pwdata[`MBCS_W0_FC +: 8];
            e_node[gi] <= pwdata[`MBCS_W0_NODE +: 8];
          end
          if (wr_ent && tbl_word == 2'h1) e_ia[gi] <= pwdata[17:0];
          if (wr_ent && tbl_word == 2'h2)
          begin
            e_cnt[gi]  <= pwdata[9:0];
            e_poll[gi] <= pwdata[`MBCS_W2_POLL +: 16];
          end
          if (wr_ent && tbl_word == 2'h3) e_ra[gi] <= pwdata[15:0];
          dirty    <= touch || (dirty && !mine);                                   // set wins
          trig[gi] <= (trig_wr && pwdata[3:0] == 4'(gi)) || (trig[gi] && !mine);
          // one extra tick so a run never follows sooner than the full period
          if (mine) tmr <= (e_poll[gi] == 16'h0000) ? 17'h00000 : {1'b0, e_poll[gi]} + 17'h00001;
          else if (sec_tick && tmr != '0) tmr <= tmr - 17'h00001;
        end
      end
    end
  endgenerate

  // --------------------------------------------------------------------------
  // current entry, validation
  // --------------------------------------------------------------------------
  logic [3:0] trig_idx;
  always_comb
  begin
    trig_idx = 4'h0;
    for (int i = N - 1; i >= 0; i--)
    begin
      if (trig[i]) trig_idx = 4'(i);
    end
  end

  wire [1:0]  c_mode = e_mode[cur_idx];
  wire [7:0]  c_fc   = e_fc[cur_idx];
  wire [7:0]  c_node = e_node[cur_idx];
  wire [17:0] c_ia   = e_ia[cur_idx];
  wire        c_bit  = f_isbit(c_fc);
  wire        c_wr   = f_iswr(c_fc);
  wire [9:0]  c_cnt  = f_cnt(c_fc, e_cnt[cur_idx]);
  wire [13:0] c_ws   = f_ws(c_fc, c_ia);
  wire [7:0]  c_nw   = f_nw(c_fc, c_ia, e_cnt[cur_idx]);
  wire [18:0] c_end  = {1'b0, c_ia} + {9'h000, c_cnt};
  wire        fc_ok  = c_bit || c_wr || (c_fc == FC_RD_HOLD) || (c_fc == FC_RD_INREG);
  wire        cnt_ok = (c_cnt != 10'h000)
                     && (c_cnt <= (c_bit ? `MBCS_BIT_CNT_MAX : `MBCS_REG_CNT_MAX));
  wire        adr_ok = c_end <= (c_bit ? `MBCS_BIT_LIMIT : `MBCS_WORD_LIMIT);
  wire        nod_ok = (c_node != `MBCS_NODE_BCAST) || c_wr;
  wire        mod_ok = ((c_mode != MODE_EVENT) || c_wr)
                     && ((c_mode != MODE_COND) || c_fc == FC_WR_COIL || c_fc == FC_WR_COILS);
  wire        c_ok   = fc_ok && cnt_ok && adr_ok && nod_ok && mod_ok;

  // --------------------------------------------------------------------------
  // database access
  // --------------------------------------------------------------------------
  logic [15:0] db [0:9999];
  logic        req_in_ready;

  wire [13:0] a0     = c_ws + {6'h00, ptr};
  wire [13:0] a1     = a0 + 14'h0001;
  wire        has1   = ({1'b0, ptr} + 9'h001) < {1'b0, c_nw};
  wire [15:0] m0     = f_mask(c_bit, a0, c_ia, c_cnt);
  wire [15:0] m1     = f_mask(c_bit, a1, c_ia, c_cnt);
  wire [15:0] rd0    = db[a0];
  wire [15:0] rd1    = has1 ? db[a1] : 16'h0000;
  wire        push_d = (state == S_DATA) && !apb_db_wr && req_in_ready;
  wire [31:0] rsw    = f_swap(resp_data, e_swap[cur_idx]);
  wire        take_r = (state == S_WAIT) && resp_valid && resp_ready && !c_wr && (ptr < c_nw);
  wire        clr_b  = push_d && (c_mode == MODE_COND);
  wire        db_we0 = clr_b || take_r;
  wire        db_we1 = db_we0 && has1;
  wire [15:0] db_d0  = clr_b ? (rd0 & ~m0) : ((rd0 & ~m0) | (rsw[31:16] & m0));
  wire [15:0] db_d1  = clr_b ? (db[a1] & ~m1) : ((db[a1] & ~m1) | (rsw[15:0] & m1));

  assign resp_ready = !apb_db_wr;

  always_ff @(posedge pclk)
  begin
    if (ce && apb_db_wr) db[db_idx] <= pwdata[15:0];
    if (ce && db_we0) db[a0] <= db_d0;
    if (ce && db_we1) db[a1] <= db_d1;
  end

  // --------------------------------------------------------------------------
  // request words into the fifo
  // --------------------------------------------------------------------------
  wire [31:0] hdr0 = {c_node, c_fc, e_ra[cur_idx]};
  wire [31:0] hdr1 = {12'h000, (c_bit ? c_ia[3:0] : 4'h0), 6'h00, c_cnt};
  wire        fin_valid = (state == S_HDR0) || (state == S_HDR1) || ((state == S_DATA) && !apb_db_wr);
  wire [31:0] fin_data  = (state == S_HDR0) ? hdr0 :
                          (state == S_HDR1) ? hdr1 : f_swap({rd0, rd1}, e_swap[cur_idx]);

  mbcs_fifo #(
    .WIDTH (32),
    .DEPTH (`MBCS_FIFO_DEPTH)
  ) u_fifo (
    .pclk      (pclk),
    .presetn   (presetn),
    .ce        (ce),
    .in_valid  (fin_valid),
    .in_ready  (req_in_ready),
    .in_data   (fin_data),
    .out_valid (req_valid),
    .out_ready (req_ready),
    .out_data  (req_data)
  );

  // --------------------------------------------------------------------------
  // scheduler
  // --------------------------------------------------------------------------
  wire any_trig = (trig != '0);
  wire end_req  = resp_done || resp_timeout;

  always_comb
  begin
    next_state = state;
    case (state)
      S_IDLE:  if (any_trig || (run && due[scan_idx])) next_state = S_CHECK;
      S_CHECK: next_state = c_ok ? S_HDR0 : S_IDLE;
      S_HDR0:  if (req_in_ready) next_state = S_HDR1;
      S_HDR1:  if (req_in_ready) next_state = c_wr ? S_DATA : S_WAIT;
      S_DATA:  if (push_d && ({1'b0, ptr} + 9'h002 >= {1'b0, c_nw})) next_state = S_WAIT;
      S_WAIT:  if (end_req) next_state = S_IDLE;
      default: next_state = S_IDLE;
    endcase
  end

  wire leave    = ((state == S_CHECK) && !c_ok) || ((state == S_WAIT) && end_req);
  wire scan_adv = ((state == S_IDLE) && !any_trig && run && !due[scan_idx]) || (leave && from_scan);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state     <= S_IDLE;
      cur_idx   <= 4'h0;
      scan_idx  <= 4'h0;
      from_scan <= 1'b0;
      ptr       <= 8'h00;
      run       <= `MBCS_CTRL_RESET;
      err_st    <= 1'b0;
      tmo_st    <= 1'b0;
      prdata    <= 32'h00000000;
    end
    else if (ce)
    begin
      state <= next_state;
      if (state == S_IDLE)
      begin
        cur_idx   <= any_trig ? trig_idx : scan_idx;
        from_scan <= !any_trig;
      end
      if (scan_adv) scan_idx <= scan_idx + 4'h1;
      if (state == S_HDR1 || state == S_CHECK) ptr <= 8'h00;
      else if (push_d || take_r) ptr <= ptr + 8'h02;
      if (apb_wr && ctrl_hit) run <= pwdata[`MBCS_CTRL_RUN];
      // hardware set wins over a write-one clear in the same cycle
      err_st <= ((state == S_CHECK) && !c_ok) || (err_st && !(stat_wr && pwdata[`MBCS_ST_ERR]));
      tmo_st <= ((state == S_WAIT) && resp_timeout) || (tmo_st && !(stat_wr && pwdata[`MBCS_ST_TMO]));
      if (apb_setup)
      begin
        prdata <= 32'h00000000;
        if (ctrl_hit) prdata[`MBCS_CTRL_RUN] <= run;
        if (stat_hit) prdata <= {22'h000000, tmo_st, err_st, 3'h0, (state != S_IDLE), cur_idx};
        if (db_hit) prdata <= {16'h0000, db[db_idx]};
        if (tbl_hit)
        begin
          case (tbl_word)
            2'h0: prdata <= {8'h00, e_node[tbl_idx], e_fc[tbl_idx], 2'h0, e_swap[tbl_idx], 2'h0, e_mode[tbl_idx]};
            2'h1: prdata <= {14'h0000, e_ia[tbl_idx]};
            2'h2: prdata <= {e_poll[tbl_idx], 6'h00, e_cnt[tbl_idx]};
            default: prdata <= {16'h0000, e_ra[tbl_idx]};
          endcase
        end
      end
    end
  end

endmodule

`default_nettype wire

// File: mbcs_top_assertions.sv
/*
  Port checker of the command scheduler.
  Assumes a bind to mbcs_top, one clock pclk, reset presetn active low.
*/
`timescale 1ns/1ps
`default_nettype none
module mbcs_chk (
  input wire logic        pclk,         // clock
  input wire logic        presetn,      // reset
  input wire logic        ce,           // enable
  input wire logic        psel,         // select
  input wire logic        penable,      // access
  input wire logic        pwrite,       // write
  input wire logic [19:0] paddr,        // address
  input wire logic [31:0] pwdata,       // wdata
  input wire logic [31:0] prdata,       // rdata
  input wire logic        pready,       // ready
  input wire logic        pslverr,      // error
  input wire logic        sec_tick,     // tick
  input wire logic        req_valid,    // req valid
  input wire logic        req_ready,    // req pop
  input wire logic [31:0] req_data,     // req word
  input wire logic        resp_valid,   // resp valid
  input wire logic        resp_ready,   // resp take
  input wire logic [31:0] resp_data,    // resp word
  input wire logic        resp_done,    // done
  input wire logic        resp_timeout  // timeout
);
  // ---------------------------------------------------------------
  // port relations
  // ---------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_access;
    psel && penable;
  endsequence
  sequence s_held;
    req_valid && $stable(req_data);
  endsequence
  chk_ready_always: assert property (pready) else $error("pready low");
  chk_err_access: assert property (pslverr |-> s_access) else $error("slverr outside access");
  chk_err_rdzero: assert property (pslverr && !pwrite |-> prdata == 32'h0) else $error("refused read data");
  chk_regs_mapped: assert property (s_access ##0 paddr inside {20'h0, 20'h4, 20'h8} |-> !pslverr)
    else $error("mapped register refused");
  chk_hole_refused: assert property (s_access ##0 paddr == 20'hC |-> pslverr) else $error("hole accepted");
  chk_req_hold: assert property (req_valid && !req_ready |=> s_held) else $error("request word moved");
  chk_valid_drop: assert property ($fell(req_valid) |-> $past(req_ready)) else $error("request lost");
  chk_resp_block: assert property (!resp_ready |-> s_access ##0 pwrite && paddr[19:16] == 4'h1)
    else $error("response refused");
  chk_reset_empty: assert property ($rose(presetn) |-> !req_valid) else $error("request after reset");
endmodule
bind mbcs_top mbcs_chk chk_u (.pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
  .pready, .pslverr, .sec_tick, .req_valid, .req_ready, .req_data, .resp_valid, .resp_ready, .resp_data,
  .resp_done, .resp_timeout);
`default_nettype wire

// File: mbcs_drv_model.sv
/*
  Serial master driver model: pops requests, answers reads, ends each with done.
  Assumes the request and response streams of mbcs_top.
*/
`timescale 1ns/1ps
`default_nettype none
module mbcs_drv_model (
  input  wire logic        pclk,       // clock
  input  wire logic        slow,       // stall pops
  input  wire logic        req_valid,  // word there
  output logic             req_ready,  // pop
  input  wire logic [31:0] req_data,   // word
  output logic             resp_valid, // read word valid
  input  wire logic        resp_ready, // taken
  output logic      [31:0] resp_data,  // read word
  output logic             resp_done   // finished
);
  logic [31:0] log_q[$];
  logic [31:0] w0;
  logic [31:0] w1;
  int          nw, k, bad;
  // ---------------------------------------------------------------
  // request handling
  // ---------------------------------------------------------------
  task automatic pop(output logic [31:0] w);
    do @(posedge pclk); while (!(req_valid && req_ready));
    w = req_data;
    log_q.push_back(w);
  endtask
  // slow mode stalls every other cycle
  always @(posedge pclk) req_ready <= slow ? !req_ready : 1'b1;
  initial
  begin
    resp_valid = 1'b0;
    resp_data  = 32'h0;
    resp_done  = 1'b0;
    bad        = 0;
    forever
    begin
      pop(w0);
      pop(w1);
      nw = (w0[23:16] inside {8'h01, 8'h02, 8'h05, 8'h0F}) ? (w1[19:16] + w1[9:0] + 15) / 16 : w1[9:0];
      if (w0[23:16] < 8'h05)
      begin
        if (w0[31:24] == 8'h00) bad++;
        for (k = 0; k < (nw + 1) / 2; k++)
        begin
          resp_valid <= 1'b1;
          resp_data  <= 32'hA1B2C3D4 + k;
          do @(posedge pclk); while (!resp_ready);
        end
        resp_valid <= 1'b0;
        resp_data  <= ~resp_data;
      end
      else
        for (k = 0; k < (nw + 1) / 2; k++) pop(w0);
      resp_done <= 1'b1;
      @(posedge pclk);
      resp_done <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// File: mbcs_tb_top.sv
/*
  Bench of the command scheduler: apb tasks, scenarios, verdict.
  Assumes mbcs_top, mbcs_drv_model and the bound checker.
*/
`timescale 1ns/1ps
`default_nettype none
module mbcs_tb_top
  import mbcs_pkg::*;
;
  logic        pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, sec_tick, e;
  logic        req_valid, req_ready, resp_valid, resp_ready, resp_done, resp_timeout, slow;
  logic [19:0] paddr;
  logic [31:0] pwdata, prdata, req_data, resp_data, q;
  int          fails = 0, tests_run = 0, b;
  mbcs_top dut_u (.pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .sec_tick, .req_valid, .req_ready, .req_data, .resp_valid, .resp_ready, .resp_data,
    .resp_done, .resp_timeout);
  mbcs_drv_model m_u (.pclk, .slow, .req_valid, .req_ready, .req_data, .resp_valid, .resp_ready,
    .resp_data, .resp_done);
  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      fails++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [19:0] a, input logic [31:0] d);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic ent(input logic [3:0] i, input logic [1:0] md, sw, input logic [7:0] fc, nd,
                     input logic [17:0] ad, input logic [9:0] cn, input logic [15:0] pl);
    apb(1'b1, {12'h001, i, 4'h0}, {8'h00, nd, fc, 2'b00, sw, 2'b00, md});
    apb(1'b1, {12'h001, i, 4'h4}, {14'h0, ad});
    apb(1'b1, {12'h001, i, 4'h8}, {pl, 6'h0, cn});
    apb(1'b1, {12'h001, i, 4'hC}, 32'h5);
  endtask
  task automatic wdone;
    int n;
    for (n = 0; n < 400 && resp_done !== 1'b1; n++) @(posedge pclk);
    chk({31'h0, resp_done}, 32'h1);
    @(posedge pclk);
  endtask
  task automatic poll(input int bp, input logic v);
    int n;
    for (n = 0; n < 40; n++)
    begin
      apb(1'b0, 20'h00004, 32'h0);
      if (q[bp] === v) break;
    end
  endtask
  task automatic wrap_up;
    if (fails == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic sc_regs;
    apb(1'b0, 20'h00000, 32'h0);
    chk(q, 32'h0);
    apb(1'b0, 20'h0000C, 32'h0);
    chk({31'h0, e}, 32'h1);
    chk(q, 32'h0);
  endtask
  task automatic sc_swap;
    logic [31:0] x[4] = '{32'h11223344, 32'h33441122, 32'h44332211, 32'h22114433};
    apb(1'b1, 20'h10190, 32'h1122);
    apb(1'b1, 20'h10194, 32'h3344);
    for (int s = 0; s < 4; s++)
    begin
      b = m_u.log_q.size();
      ent(4'h0, MODE_DISABLED, s[1:0], FC_WR_REGS, 8'h07, 18'd100, 10'd2, 16'h0);
      apb(1'b1, 20'h00008, 32'h0);
      wdone;
      chk(m_u.log_q[b], 32'h07100005);
      chk(m_u.log_q[b + 1], 32'h00000002);
      chk(m_u.log_q[b + 2], x[s]);
    end
    b = m_u.log_q.size();
    ent(4'h1, MODE_DISABLED, SWAP_NONE, FC_WR_REG, 8'h02, 18'd100, 10'd9, 16'h0);
    apb(1'b1, 20'h00008, 32'h1);
    wdone;
    chk(m_u.log_q[b + 1], 32'h00000001);
    chk(m_u.log_q[b + 2], 32'h11220000);
    chk(m_u.log_q.size(), b + 3);
  endtask
  task automatic sc_read;
    slow <= 1'b1;
    ent(4'h2, MODE_DISABLED, SWAP_NONE, FC_RD_HOLD, 8'h03, 18'd200, 10'd2, 16'h0);
    apb(1'b1, 20'h00008, 32'h2);
    wdone;
    apb(1'b0, 20'h10320, 32'h0);
    chk({16'h0, q[15:0]}, 32'h0000A1B2);
    apb(1'b0, 20'h10324, 32'h0);
    chk({16'h0, q[15:0]}, 32'h0000C3D4);
    slow <= 1'b0;
  endtask
  task automatic sc_refuse;
    b = m_u.log_q.size();
    ent(4'h3, MODE_DISABLED, SWAP_NONE, 8'h07, 8'h01, 18'd0, 10'd1, 16'h0);
    apb(1'b1, 20'h00008, 32'h3);
    poll(8, 1'b1);
    chk({31'h0, q[8]}, 32'h1);
    apb(1'b1, 20'h00004, 32'h100);
    apb(1'b0, 20'h00004, 32'h0);
    chk({31'h0, q[8]}, 32'h0);
    ent(4'h4, MODE_DISABLED, SWAP_NONE, FC_RD_HOLD, 8'h00, 18'd0, 10'd1, 16'h0);
    apb(1'b1, 20'h00008, 32'h4);
    poll(8, 1'b1);
    chk({31'h0, q[8]}, 32'h1);
    chk(m_u.log_q.size(), b);
    chk(m_u.bad, 0);
  endtask
  task automatic sc_scan;
    int n[256];
    int i;
    ent(4'h5, MODE_CONT, SWAP_NONE, FC_WR_REG, 8'h09, 18'd0, 10'd1, 16'h0);
    ent(4'h6, MODE_CONT, SWAP_NONE, FC_WR_REG, 8'h0A, 18'd0, 10'd1, 16'h2);
    ent(4'h7, MODE_COND, SWAP_NONE, FC_WR_COILS, 8'h04, 18'd1603, 10'd5, 16'h0);
    ent(4'h8, MODE_EVENT, SWAP_NONE, FC_WR_REG, 8'h05, 18'd300, 10'd1, 16'h0);
    b = m_u.log_q.size();
    apb(1'b1, 20'h00000, 32'h1);
    for (i = 0; i < 6; i++)
    begin
      repeat (99) @(posedge pclk);
      sec_tick <= 1'b1;
      @(posedge pclk);
      sec_tick <= 1'b0;
      if (i == 1)
      begin
        apb(1'b1, 20'h10190, 32'h1122);
        apb(1'b1, 20'h104B0, 32'hBEEF);
      end
    end
    apb(1'b1, 20'h00000, 32'h0);
    poll(4, 1'b0);
    for (i = b; i < m_u.log_q.size(); i += 3)
    begin
      n[m_u.log_q[i][31:24]]++;
      if (m_u.log_q[i][31:24] == 8'h04) chk(m_u.log_q[i + 1], 32'h00030005);
    end
    chk(n[7] + n[2] + n[3] + n[1] + n[0], 0);
    chk(n[9] > 5, 1);
    chk(n[10] >= 1 && n[10] <= 4, 1);
    chk(n[4], 1);
    chk(n[5], 1);
    apb(1'b0, 20'h10190, 32'h0);
    chk({16'h0, q[15:0]}, 32'h00001102);
  endtask
  // ---------------------------------------------------------------
  // clock, watchdog, main sequence
  // ---------------------------------------------------------------
  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  initial
  begin
    #200000;
    fails++;
    wrap_up;
  end
  initial
  begin
    {presetn, psel, penable, pwrite, sec_tick, slow, resp_timeout, paddr, pwdata} = '0;
    ce = 1'b1;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    sc_regs;
    sc_swap;
    sc_read;
    sc_refuse;
    sc_scan;
    wrap_up;
  end
endmodule
`default_nettype wire
